//--- hw/acd_pkg.sv
package acd_pkg;
  // ==========================================
  // register offsets (core address space)
  localparam logic [23:0] ACD_CONFIG_ADDR    = 24'h00ff22;
  localparam logic [23:0] ACD_CLKDIV_ADDR    = 24'h00ff24;
  localparam logic [23:0] ACD_STATUS_ADDR    = 24'h00ff20;
  // ==========================================
  // configuration fields
  localparam int          ACD_EN_BIT         = 0;
  localparam int          ACD_REMOTE_BIT     = 1;
  localparam int          ACD_EOC_IE_BIT     = 2;
  localparam int          ACD_OT_IE_BIT      = 3;
  localparam int          ACD_OS_IE_BIT      = 4;
  localparam logic [7:0]  ACD_CONFIG_RESET   = 8'h00;
  localparam logic [7:0]  ACD_CONFIG_MASK    = 8'h1f;
  // ==========================================
  // clock divider fields
  localparam int          ACD_DIV_W          = 6;
  localparam logic [7:0]  ACD_CLKDIV_RESET   = 8'h3f;
  localparam logic [7:0]  ACD_CLKDIV_MASK    = 8'h3f;
  // ==========================================
  // status fields
  localparam int          ACD_EOC_BIT        = 0;
  localparam int          ACD_OT_BIT         = 2;
  localparam int          ACD_OS_BIT         = 3;
endpackage

//--- hw/acd_div_if.sv
`timescale 1ns/1ps
// ==========================================
// divider control and tick between top and divider
interface acd_div_if;
  logic       run;
  logic [5:0] factor;
  logic       tick;
  modport ctrl (output run, output factor, input tick);
  modport div  (input run, input factor, output tick);
endinterface

//--- hw/acd_clk_div.sv
`timescale 1ns/1ps
// ==========================================
// system clock divider producing converter clock ticks
module acd_clk_div
  import acd_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  // control
  acd_div_if.div    dv
);
  typedef struct packed {
    logic [ACD_DIV_W-1:0] cnt;
    logic                 tick;
  } acd_div_s;

  acd_div_s st;
  acd_div_s next_st;

  // count down factor cycles, one tick per period
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (!dv.run) begin
      next_st.cnt = '0;
    end else if (st.cnt == '0) begin
      next_st.cnt  = dv.factor - 6'h01;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt - 6'h01;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dv.tick = st.tick;
endmodule

//--- hw/acd_config.sv
`timescale 1ns/1ps
// Notes on behaviour
// - converter runs only while the module enable bit is one.
// - remote select zero routes pins to voltage inputs, forces remote measure off.
// - with remote select and measure enable, temperature alternates remote and local.
// - end-of-cycle event interrupts only when its enable is set; resets disabled.
// - overtemperature event interrupts only when its enable is set; resets disabled.
// - open/short event interrupts only when its enable is set; resets disabled.
// - converter clock is system clock divided by 6-bit factor, reset 63.
// - end-of-cycle flag sets when cycle done, holds until all data-valid clear.
// - overtemp and open/short flags set by events, cleared by writing one.
module acd_config
  import acd_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  // peripheral bus
  input  wire logic [23:0] bus_addr_in,
  input  wire logic        bus_wr_in,
  input  wire logic        bus_rd_in,
  input  wire logic [7:0]  bus_wdata_in,
  output logic      [7:0]  bus_rdata_out,
  // converter events
  input  wire logic        cycle_done_in,
  input  wire logic        any_data_valid_in,
  input  wire logic        overtemp_event_in,
  input  wire logic        open_short_event_in,
  // converter control
  input  wire logic        remote_measure_enable_in,
  output logic             converter_module_enable_out,
  output logic             remote_diode_select_out,
  output logic             remote_measure_enable_out,
  output logic             measure_remote_now_out,
  output logic             converter_clk_tick_out,
  output logic             converter_irq_out
);
  // ==========================================
  // usage notes
  // register writes reach the control outputs two clocks after the write strobe
  // read data stands for one clock after the read strobe and is zero otherwise
  // factors below four are not trapped: one ticks every clock, zero every 64
  // the tick output is gated with the enable, so a tick in flight is dropped
  // the remote sequence restarts on local whenever remote measuring is dropped
  // open/short events count only while remote measuring is in effect
  // overtemperature and end-of-cycle events count only while the converter runs
  // a flag set in the same clock as its clear stays set, so no event is lost

  // ==========================================
  // state of the block
  typedef struct packed {
    // software registers
    logic [7:0] cfg;
    logic [7:0] div;
    // event flags and remote sequencing
    logic       eoc;
    logic       ot;
    logic       os;
    logic       remote_phase;
    // registered outputs
    logic       irq;
    logic       tick;
    logic       en;
    logic       rsel;
    logic       rmeas;
    logic       rnow;
    logic [7:0] rdata;
  } acd_cfg_s;

  // current and next state
  acd_cfg_s   st;
  acd_cfg_s   next_st;
  acd_div_if  dv ();

  // ==========================================
  // divider
  assign dv.run    = st.cfg[ACD_EN_BIT];
  assign dv.factor = st.div[ACD_DIV_W-1:0];

  acd_clk_div u_div (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .dv         (dv)
  );

  // ==========================================
  // register select indices
  localparam int SEL_CFG = 0;
  localparam int SEL_DIV = 1;
  localparam int SEL_STS = 2;
  localparam int SEL_W   = 3;

  // ==========================================
  // helper functions
  // one-hot register select, shared by the write and the read path
  function automatic logic [SEL_W-1:0] reg_hit(input logic [23:0] addr);
    logic [SEL_W-1:0] hit;
    hit          = '0;
    hit[SEL_CFG] = (addr == ACD_CONFIG_ADDR);
    hit[SEL_DIV] = (addr == ACD_CLKDIV_ADDR);
    hit[SEL_STS] = (addr == ACD_STATUS_ADDR);
    return hit;
  endfunction

  // sticky event flag; a set in the clearing cycle must not be lost
  function automatic logic sticky_flag(input logic flag,
                                       input logic set,
                                       input logic clear);
    logic nxt;
    nxt = flag;
    if (clear) begin
      nxt = 1'b0;
    end
    if (set) begin
      nxt = 1'b1;
    end
    return nxt;
  endfunction

  // one interrupt source: flag qualified by its enable
  function automatic logic irq_term(input logic flag, input logic enable);
    return flag && enable;
  endfunction

  // status byte image, unused bits read zero
  function automatic logic [7:0] status_byte(input logic eoc,
                                             input logic ot,
                                             input logic os);
    logic [7:0] img;
    img              = 8'h00;
    img[ACD_EOC_BIT] = eoc;
    img[ACD_OT_BIT]  = ot;
    img[ACD_OS_BIT]  = os;
    return img;
  endfunction

  // ==========================================
  // next state
  always_comb begin
    logic [SEL_W-1:0] wr_hit;
    logic [SEL_W-1:0] rd_hit;
    logic             run;
    logic             meas_ok;
    logic             ot_clr;
    logic             os_clr;
    wr_hit  = bus_wr_in ? reg_hit(bus_addr_in) : '0;
    rd_hit  = bus_rd_in ? reg_hit(bus_addr_in) : '0;
    run     = st.cfg[ACD_EN_BIT];
    meas_ok = st.cfg[ACD_REMOTE_BIT] && remote_measure_enable_in;
    ot_clr  = wr_hit[SEL_STS] && bus_wdata_in[ACD_OT_BIT];
    os_clr  = wr_hit[SEL_STS] && bus_wdata_in[ACD_OS_BIT];
    next_st = st;
    // register writes, reserved bits held at zero
    if (wr_hit[SEL_CFG]) begin
      next_st.cfg = bus_wdata_in & ACD_CONFIG_MASK;
    end
    if (wr_hit[SEL_DIV]) begin
      next_st.div = bus_wdata_in & ACD_CLKDIV_MASK;
    end
    // end-of-cycle flag: set by cycle end, held while any data valid
    if (cycle_done_in && run) begin
      next_st.eoc = 1'b1;
    end else if (!any_data_valid_in) begin
      next_st.eoc = 1'b0;
    end
    // write-one-to-clear flags, set wins over clear
    next_st.ot = sticky_flag(st.ot, overtemp_event_in && run, ot_clr);
    next_st.os = sticky_flag(st.os, open_short_event_in && st.rmeas, os_clr);
    // remote measure forced off without remote select
    next_st.en    = run;
    next_st.rsel  = st.cfg[ACD_REMOTE_BIT];
    next_st.rmeas = meas_ok;
    // alternate remote and local each completed cycle, local first
    if (!meas_ok || !run) begin
      next_st.remote_phase = 1'b0;
    end else if (cycle_done_in) begin
      next_st.remote_phase = !st.remote_phase;
    end
    next_st.rnow  = meas_ok && next_st.remote_phase;
    // divider tick gated so none escapes once the enable drops
    next_st.tick  = dv.tick && run;
    // combined interrupt, one clock behind the flags
    next_st.irq   = irq_term(st.eoc, st.cfg[ACD_EOC_IE_BIT])
                  | irq_term(st.ot,  st.cfg[ACD_OT_IE_BIT])
                  | irq_term(st.os,  st.cfg[ACD_OS_IE_BIT]);
    // read data, unmapped reads zero
    next_st.rdata = 8'h00;
    if (rd_hit[SEL_CFG]) begin
      next_st.rdata = st.cfg;
    end else if (rd_hit[SEL_DIV]) begin
      next_st.rdata = st.div;
    end else if (rd_hit[SEL_STS]) begin
      next_st.rdata = status_byte(st.eoc, st.ot, st.os);
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      // flags and outputs clear, registers take their reset images
      st      <= '0;
      st.cfg  <= ACD_CONFIG_RESET;
      st.div  <= ACD_CLKDIV_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // outputs straight from flops
  // bus read data
  assign bus_rdata_out               = st.rdata;
  // converter control
  assign converter_module_enable_out = st.en;
  assign remote_diode_select_out     = st.rsel;
  assign remote_measure_enable_out   = st.rmeas;
  assign measure_remote_now_out      = st.rnow;
  assign converter_clk_tick_out      = st.tick;
  // interrupt request
  assign converter_irq_out           = st.irq;
endmodule

//--- tb/acd_config_checker.sv
`timescale 1ns/1ps
// ==========================================
// port checks for the configuration block
module acd_config_checker
  import acd_pkg::*;
(
  // all ports of the block
  input wire logic        sys_clk_in, reset_in, bus_wr_in, bus_rd_in,
  input wire logic [23:0] bus_addr_in,
  input wire logic [7:0]  bus_wdata_in, bus_rdata_out,
  input wire logic        cycle_done_in, any_data_valid_in, overtemp_event_in,
  input wire logic        open_short_event_in, remote_measure_enable_in,
  input wire logic        converter_module_enable_out, remote_diode_select_out,
  input wire logic        remote_measure_enable_out, measure_remote_now_out,
  input wire logic        converter_clk_tick_out, converter_irq_out
);
  // anything that may raise the interrupt
  wire logic cause = cycle_done_in | overtemp_event_in | open_short_event_in | bus_wr_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  en_follows_write_a: assert property (bus_wr_in && bus_addr_in == ACD_CONFIG_ADDR |->
    ##2 converter_module_enable_out == $past(bus_wdata_in[0], 2)) else $error("enable wrong");
  no_tick_off_a: assert property (!converter_module_enable_out &&
    !$past(converter_module_enable_out) |-> !converter_clk_tick_out) else $error("tick while off");
  remote_forced_a: assert property (!remote_diode_select_out |->
    !remote_measure_enable_out) else $error("remote measure not forced off");
  remote_phase_a: assert property (measure_remote_now_out |->
    remote_measure_enable_out) else $error("remote phase without enable");
  tick_gap_a: assert property (converter_clk_tick_out |=>
    !converter_clk_tick_out) else $error("ticks too close");
  rdata_idle_a: assert property (!$past(bus_rd_in) |-> bus_rdata_out == 8'h00)
    else $error("read data without read");
  div_reserved_a: assert property (bus_rd_in && bus_addr_in == ACD_CLKDIV_ADDR |=>
    bus_rdata_out[7:6] == 2'h0) else $error("divider reserved bits set");
  irq_cause_a: assert property ($rose(converter_irq_out) |-> $past(cause) ||
    $past(cause, 2) || $past(cause, 3)) else $error("interrupt without cause");
  remote_toggle_a: assert property (cycle_done_in && converter_module_enable_out &&
    remote_measure_enable_out && !$past(bus_wr_in) && $stable(remote_measure_enable_in)
    |=> measure_remote_now_out != $past(measure_remote_now_out))
    else $error("remote phase did not alternate");
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
// ==========================================
// register level bench
module tb_top
  import acd_pkg::*;
;
  logic        sys_clk_in, reset_in, bus_wr_in, bus_rd_in, any_data_valid_in;
  logic        remote_measure_enable_in, converter_module_enable_out, remote_diode_select_out;
  logic        remote_measure_enable_out, measure_remote_now_out;
  logic        converter_clk_tick_out, converter_irq_out;
  logic [23:0] bus_addr_in;
  logic [7:0]  bus_wdata_in, bus_rdata_out;
  logic [2:0]  evs;
  wire logic   cycle_done_in, overtemp_event_in, open_short_event_in;
  int          fail_count, compares, n;
  assign {open_short_event_in, overtemp_event_in, cycle_done_in} = evs;
  acd_config uut (.*);
  // system clock
  initial begin
    sys_clk_in = 0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  task automatic step(int c);
    repeat (c) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [23:0] a, logic [7:0] d);
    bus_addr_in = a;
    bus_wdata_in = d;
    bus_wr_in = 1;
    step(1);
    bus_wr_in = 0;
    step(1);
  endtask
  task automatic rd(logic [23:0] a, logic [7:0] exp);
    bus_addr_in = a;
    bus_rd_in = 1;
    step(1);
    bus_rd_in = 0;
    chk(bus_rdata_out, exp);
    step(1);
  endtask
  // cycles from one converter tick to the next
  task automatic gap(int exp);
    n = 0;
    while (converter_clk_tick_out !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    n = 0;
    do begin
      step(1);
      n++;
    end while (converter_clk_tick_out !== 1'b1 && n < 300);
    chk(n[7:0], exp[7:0]);
  endtask
  task automatic close_out();
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog
  initial begin
    #60000;
    fail_count++;
    close_out();
  end
  // main sequence
  initial begin
    {reset_in, bus_wr_in, bus_rd_in, evs, any_data_valid_in, remote_measure_enable_in} = 8'h80;
    bus_addr_in = 24'h000000;
    bus_wdata_in = 8'h00;
    repeat (10) @(posedge sys_clk_in);
    #1 reset_in = 0;
    step(1);
    rd(ACD_CONFIG_ADDR, 8'h00);
    rd(ACD_CLKDIV_ADDR, 8'h3f);
    wr(ACD_CLKDIV_ADDR, 8'hff);
    rd(ACD_CLKDIV_ADDR, 8'h3f);
    wr(ACD_CONFIG_ADDR, 8'hfe);
    wr(24'h00ff30, 8'h00);
    rd(24'h00ff30, 8'h00);
    rd(ACD_CONFIG_ADDR, 8'h1e);
    chk({converter_module_enable_out, converter_irq_out}, 2'b00);
    wr(ACD_CLKDIV_ADDR, 8'h04);
    wr(ACD_CONFIG_ADDR, 8'h01);
    gap(4);
    wr(ACD_CLKDIV_ADDR, 8'h3f);
    step(70);
    gap(63);
    remote_measure_enable_in = 1;
    step(3);
    chk(remote_measure_enable_out, 1'b0);
    wr(ACD_CONFIG_ADDR, 8'h03);
    step(2);
    chk({remote_diode_select_out, remote_measure_enable_out, measure_remote_now_out}, 3'b110);
    for (int i = 0; i < 2; i++) begin
      evs = 3'b001;
      step(1);
      evs = 0;
      step(3);
      chk(measure_remote_now_out, i == 0);
    end
    // each event kind, masked then unmasked then cleared
    for (int i = 0; i < 3; i++) begin
      any_data_valid_in = (i == 0);
      evs = 3'b001 << i;
      step(1);
      evs = 0;
      step(3);
      chk(converter_irq_out, 1'b0);
      rd(ACD_STATUS_ADDR, i == 0 ? 8'h01 : 8'h02 << i);
      wr(ACD_CONFIG_ADDR, 8'h03 | (8'h04 << i));
      step(2);
      chk(converter_irq_out, 1'b1);
      if (i == 0) any_data_valid_in = 0;
      else wr(ACD_STATUS_ADDR, 8'h02 << i);
      step(3);
      chk(converter_irq_out, 1'b0);
      wr(ACD_CONFIG_ADDR, 8'h03);
    end
    wr(ACD_CONFIG_ADDR, 8'h00);
    step(200);
    chk(converter_module_enable_out, 1'b0);
    close_out();
  end
endmodule
bind acd_config acd_config_checker chk_i (.*);
